// >>> eac_core_model.sv
// partner model: rc oscillator and flash self-programming status of the core
// assumes the bench asks for flash activity through flash_req, on clk
`timescale 1ns/1ns
`default_nettype none
module eac_core_model (
   // clock
   input  wire logic clk,
   // bench control
   input  wire logic flash_req,
   // to the block
   output var logic  rc_tick,
   output var logic  selfprog_busy
);
   // free running and unrelated in phase to clk, as a real rc oscillator is
   initial rc_tick = 1'h0;
   always #37 rc_tick = ~rc_tick;
   always_ff @(posedge clk) begin
      selfprog_busy <= flash_req;
   end
endmodule
`default_nettype wire

// >>> eac_nvm_array.sv
// byte array standing in for the nonvolatile cells, with erase/write actions
// assumes prog is a one-cycle pulse and addr is held steady by the controller
`timescale 1ns/1ns
`default_nettype none
module eac_nvm_array (
   // clock
   input  wire logic                       clk,
   // programming
   input  wire logic                       prog,
   input  wire eac_pkg::eac_mode_t         mode,
   input  wire logic [eac_pkg::ADDR_W-1:0] addr,
   input  wire logic [7:0]                 wdata,
   // read
   output logic [7:0]                      rdata
);
   logic [7:0] mem [0:eac_pkg::DEPTH-1];

   // write-only can only clear bits, so split erase then write gives the same byte
   always_ff @(posedge clk) begin
      if (prog) begin
         case (mode)
            eac_pkg::MODE_ATOMIC: mem[addr] <= wdata;
            eac_pkg::MODE_ERASE:  mem[addr] <= eac_pkg::ERASED;
            eac_pkg::MODE_WRITE:  mem[addr] <= mem[addr] & wdata;
            default:              mem[addr] <= mem[addr];
         endcase
      end
   end

   assign rdata = mem[addr];
endmodule
`default_nettype wire

// >>> eac_pkg.sv
// package for the nonvolatile access controller: register map, fields, timing
// assumes the cpu i/o port and the rc oscillator tick come from the core
package eac_pkg;
   localparam logic [5:0] ADDR_CTRL = 6'h1F;
   localparam logic [5:0] ADDR_DATA = 6'h20;
   localparam logic [5:0] ADDR_ALO  = 6'h21;
   localparam logic [5:0] ADDR_AHI  = 6'h22;
   localparam int BIT_READ    = 0;
   localparam int BIT_STROBE  = 1;
   localparam int BIT_ARM     = 2;
   localparam int BIT_IRQEN   = 3;
   localparam int BIT_MODE_LO = 4;
   localparam int BIT_MODE_HI = 5;
   localparam int ADDR_W      = 10;
   localparam int DEPTH       = 1024;
   localparam int COUNT_W     = 15;
   localparam logic [2:0] ARM_CYCLES = 3'h4;
   localparam logic [2:0] WR_STALL   = 3'h2;
   localparam logic [2:0] RD_STALL   = 3'h4;
   localparam int RC_WRITE_CYCLES = 26368;
   localparam int T_ATOMIC_US     = 3400;
   localparam int T_SPLIT_US      = 1800;
   localparam logic [7:0] ERASED  = 8'hFF;
   typedef enum logic [1:0] {MODE_ATOMIC, MODE_ERASE, MODE_WRITE, MODE_RSVD} eac_mode_t;
   typedef enum logic {ST_IDLE, ST_PROG} eac_fsm_t;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } eac_io_req_t;
   typedef struct packed {
      eac_fsm_t          fsm;
      eac_mode_t         mode;
      logic              irq_en;
      logic [2:0]        arm_cnt;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
      logic [2:0]        stall_cnt;
      logic              stall;
      logic              irq;
      logic [7:0]        rdata;
      logic [2:0]        tick_sync;
   } eac_state_t;
   typedef struct packed {
      logic               busy;
      logic [COUNT_W-1:0] cnt;
      logic               done;
   } eac_timer_t;
endpackage

// >>> eac_rc_timer.sv
// down counter of rc oscillator ticks that times one programming operation
// assumes tick is a one-cycle pulse already synchronised to clk
`timescale 1ns/1ns
`default_nettype none
module eac_rc_timer (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // control
   input  wire logic                        load,
   input  wire logic [eac_pkg::COUNT_W-1:0] load_val,
   input  wire logic                        tick,
   // status
   output logic                             busy,
   output logic                             done
);
   eac_pkg::eac_timer_t s;
   eac_pkg::eac_timer_t next_s;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (load) begin
         next_s.busy = 1'b1;
         next_s.cnt = load_val;
      end else if (s.busy && tick) begin
         if (s.cnt == eac_pkg::COUNT_W'(1)) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end
         next_s.cnt = s.cnt - eac_pkg::COUNT_W'(1);
      end
      if (!rst_n) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign busy = s.busy;
   assign done = s.done;
endmodule
`default_nettype wire

// >>> eac_top.sv
// register front end and sequencer of the nonvolatile data store
// assumes the cpu core issues i/o writes and reads on clk and honours cpu_stall;
// rc_tick comes from the rc oscillator domain and is synchronised here
`timescale 1ns/1ns
`default_nettype none
module eac_top #(
   parameter int WRITE_RC_CYCLES = eac_pkg::RC_WRITE_CYCLES
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // cpu i/o port
   input  wire eac_pkg::eac_io_req_t io_req,
   output logic [7:0]                io_rdata,
   output logic                      cpu_stall,
   // core status
   input  wire logic                 global_irq_en,
   input  wire logic                 selfprog_busy,
   // rc oscillator tick, asynchronous
   input  wire logic                 rc_tick,
   // interrupt request
   output logic                      ready_irq
);
   localparam int SPLIT_RC_CYCLES =
      WRITE_RC_CYCLES * eac_pkg::T_SPLIT_US / eac_pkg::T_ATOMIC_US;

   eac_pkg::eac_state_t s;
   eac_pkg::eac_state_t next_s;

   logic                        ctrl_wr;
   logic                        busy;
   logic                        arm_live;
   logic                        arm_set;
   logic                        strobe_wr;
   logic                        start;
   logic                        rd_go;
   logic                        tick;
   logic                        timer_done;
   logic [eac_pkg::COUNT_W-1:0] load_val;
   logic [7:0]                  mem_rdata;
   logic [7:0]                  ctrl_view;

   assign ctrl_wr   = io_req.wr && (io_req.addr == eac_pkg::ADDR_CTRL);
   assign busy      = (s.fsm == eac_pkg::ST_PROG);
   assign arm_live  = (s.arm_cnt != 3'h0);
   assign arm_set   = ctrl_wr && io_req.wdata[eac_pkg::BIT_ARM];
   assign strobe_wr = ctrl_wr && io_req.wdata[eac_pkg::BIT_STROBE];
   // only the second and third stages feed the edge detector
   assign tick      = s.tick_sync[1] && !s.tick_sync[2];

   // strobe counts only inside the arming window, idle, flash not self-programming
   // a strobe seen in reset must not touch the cells
   assign start = rst_n && strobe_wr && arm_live && !busy && !selfprog_busy
                  && (s.mode != eac_pkg::MODE_RSVD);
   // a read strobe in the same write as a starting strobe is dropped, the write wins
   assign rd_go = ctrl_wr && io_req.wdata[eac_pkg::BIT_READ] && !busy && !start;

   // atomic takes the full count, split actions the shorter one
   assign load_val = (s.mode == eac_pkg::MODE_ATOMIC)
                     ? eac_pkg::COUNT_W'(WRITE_RC_CYCLES)
                     : eac_pkg::COUNT_W'(SPLIT_RC_CYCLES);

   assign ctrl_view = {2'h0, s.mode, s.irq_en, arm_live, busy, 1'b0};

   eac_rc_timer u_timer (
      .clk      (clk),
      .rst_n    (rst_n || busy),
      .load     (start),
      .load_val (load_val),
      .tick     (tick),
      .busy     (),
      .done     (timer_done)
   );

   eac_nvm_array u_array (
      .clk   (clk),
      .prog  (start),
      .mode  (s.mode),
      .addr  (s.addr),
      .wdata (s.data),
      .rdata (mem_rdata)
   );

   always_comb begin
      next_s = s;
      next_s.tick_sync = {s.tick_sync[1:0], rc_tick};
      if (arm_live) begin
         next_s.arm_cnt = s.arm_cnt - 3'h1;
      end
      if (s.stall_cnt != 3'h0) begin
         next_s.stall_cnt = s.stall_cnt - 3'h1;
      end
      if (ctrl_wr) begin
         next_s.irq_en = io_req.wdata[eac_pkg::BIT_IRQEN];
         if (!busy) begin
            next_s.mode = eac_pkg::eac_mode_t'(
               io_req.wdata[eac_pkg::BIT_MODE_HI:eac_pkg::BIT_MODE_LO]);
         end
         if (arm_set) begin
            next_s.arm_cnt = eac_pkg::ARM_CYCLES;
         end
      end
      if (start) begin
         next_s.fsm = eac_pkg::ST_PROG;
         next_s.arm_cnt = 3'h0;
         next_s.stall_cnt = eac_pkg::WR_STALL;
      end
      if (rd_go) begin
         next_s.data = mem_rdata;
         next_s.stall_cnt = eac_pkg::RD_STALL;
      end
      if (io_req.wr && io_req.addr == eac_pkg::ADDR_DATA) begin
         next_s.data = io_req.wdata;
      end
      // address is frozen while a byte is being programmed
      if (io_req.wr && !busy && io_req.addr == eac_pkg::ADDR_ALO) begin
         next_s.addr[7:0] = io_req.wdata;
      end
      if (io_req.wr && !busy && io_req.addr == eac_pkg::ADDR_AHI) begin
         next_s.addr[eac_pkg::ADDR_W-1:8] = io_req.wdata[eac_pkg::ADDR_W-9:0];
      end
      if (timer_done) begin
         next_s.fsm = eac_pkg::ST_IDLE;
      end
      if (io_req.rd) begin
         case (io_req.addr)
            eac_pkg::ADDR_CTRL: next_s.rdata = ctrl_view;
            eac_pkg::ADDR_DATA: next_s.rdata = s.data;
            eac_pkg::ADDR_ALO:  next_s.rdata = s.addr[7:0];
            eac_pkg::ADDR_AHI:  next_s.rdata = {6'h00, s.addr[eac_pkg::ADDR_W-1:8]};
            default:            next_s.rdata = 8'h00;
         endcase
      end
      next_s.stall = (next_s.stall_cnt != 3'h0);
      next_s.irq = next_s.irq_en && global_irq_en
                   && (next_s.fsm == eac_pkg::ST_IDLE) && !selfprog_busy;
      // a byte under programming finishes across reset; its settings survive
      // the synchroniser keeps running so a write held across reset loses no tick,
      // and a write whose timer ends inside reset is let go rather than stuck busy
      if (!rst_n) begin
         next_s = '0;
         next_s.tick_sync = {s.tick_sync[1:0], rc_tick};
         if (busy && !timer_done) begin
            next_s.fsm  = eac_pkg::ST_PROG;
            next_s.mode = s.mode;
            next_s.addr = s.addr;
            next_s.data = s.data;
         end
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign io_rdata  = s.rdata;
   assign cpu_stall = s.stall;
   assign ready_irq = s.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // interrupt request
   a_irq_enable: assert property (
      ready_irq |-> s.irq_en && $past(global_irq_en))
      else $error("ready irq without both enables");

   a_irq_off: assert property (
      !s.irq_en |-> !ready_irq)
      else $error("ready irq with enable bit clear");

   a_irq_en_write: assert property (
      ctrl_wr |=> s.irq_en == $past(io_req.wdata[eac_pkg::BIT_IRQEN]))
      else $error("irq enable bit not taken");

   a_irq_busy: assert property (
      busy || $past(selfprog_busy) |-> !ready_irq)
      else $error("ready irq while programming");

   a_irq_idle: assert property (
      !busy && s.irq_en && $past(global_irq_en) && !$past(selfprog_busy) |-> ready_irq)
      else $error("ready irq missing while idle");

   // arming window and write start
   a_arm_expiry: assert property (
      $rose(arm_live) ##0 !arm_set [*4] |-> ##1 !arm_live)
      else $error("arming window not four cycles");

   a_arm_set: assert property (
      arm_set && !start |=> arm_live)
      else $error("arming bit not set by write");

   a_strobe_noarm: assert property (
      strobe_wr && !arm_live && !busy |=> !busy)
      else $error("write started without arming");

   a_strobe_start: assert property (
      strobe_wr && arm_live && !busy && !selfprog_busy
      && s.mode != eac_pkg::MODE_RSVD |=> busy && !arm_live)
      else $error("armed strobe did not start a write");

   a_selfprog_block: assert property (
      strobe_wr && selfprog_busy && !busy |=> !busy)
      else $error("write started during self-programming");

   a_rsvd_refused: assert property (
      strobe_wr && arm_live && !busy && s.mode == eac_pkg::MODE_RSVD |=> !busy)
      else $error("write started in reserved mode");

   // cpu stall counts
   a_write_stall: assert property (
      start |=> cpu_stall [*2] ##1 !cpu_stall)
      else $error("write stall not two cycles");

   a_read_stall: assert property (
      rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
      else $error("read stall not four cycles");

   a_busy_nostall: assert property (
      busy && s.stall_cnt == 3'h0 |=> !cpu_stall)
      else $error("cpu stalled by a read while busy");

   // data, address and mode registers
   a_read_data: assert property (
      rd_go && !(io_req.wr && io_req.addr == eac_pkg::ADDR_DATA)
      |=> s.data == $past(mem_rdata))
      else $error("read byte not in data register");

   a_data_write: assert property (
      io_req.wr && io_req.addr == eac_pkg::ADDR_DATA |=> s.data == $past(io_req.wdata))
      else $error("data register not written");

   a_data_hold: assert property (
      busy && !(io_req.wr && io_req.addr == eac_pkg::ADDR_DATA) |=> $stable(s.data))
      else $error("data register changed by a read while busy");

   a_addr_write: assert property (
      !busy && io_req.wr && io_req.addr == eac_pkg::ADDR_ALO
      |=> s.addr[7:0] == $past(io_req.wdata))
      else $error("address low byte not written");

   a_addr_hold: assert property (
      busy |=> $stable(s.addr))
      else $error("address changed while busy");

   a_mode_write: assert property (
      ctrl_wr && !busy
      |=> s.mode == $past(io_req.wdata[eac_pkg::BIT_MODE_HI:eac_pkg::BIT_MODE_LO]))
      else $error("mode bits not written");

   a_mode_hold: assert property (
      busy && ctrl_wr |=> $stable(s.mode))
      else $error("mode changed while busy");

   // control readback and end of write
   a_busy_readback: assert property (
      busy && io_req.rd && io_req.addr == eac_pkg::ADDR_CTRL
      |=> io_rdata[eac_pkg::BIT_STROBE])
      else $error("strobe not read as one while busy");

   a_read_bit_zero: assert property (
      io_req.rd && io_req.addr == eac_pkg::ADDR_CTRL
      |=> !io_rdata[eac_pkg::BIT_READ] && io_rdata[7:6] == 2'h0)
      else $error("read strobe or spare bits read as one");

   a_busy_hold: assert property (
      busy && !timer_done |=> busy)
      else $error("strobe bit dropped before the write ended");

   a_prog_end: assert property (
      timer_done |=> !busy ##1 ready_irq || !s.irq_en || !$past(global_irq_en)
      || $past(selfprog_busy))
      else $error("strobe not cleared at end of write");

   // rc ticks counted while the timer runs, against the count the mode asks for;
   // kept apart from the timer so a wrong load value or a lost tick shows up
   logic [eac_pkg::COUNT_W-1:0] tick_seen;
   logic [eac_pkg::COUNT_W-1:0] tick_goal;

   always_ff @(posedge clk) begin
      if (start && s.mode == eac_pkg::MODE_ATOMIC) begin
         tick_seen <= '0;
         tick_goal <= eac_pkg::COUNT_W'(WRITE_RC_CYCLES);
      end else if (start) begin
         tick_seen <= '0;
         tick_goal <= eac_pkg::COUNT_W'(SPLIT_RC_CYCLES);
      end else if (busy && !timer_done && tick) begin
         tick_seen <= tick_seen + eac_pkg::COUNT_W'(1);
      end
   end

   a_write_time: assert property (
      timer_done |-> tick_seen == tick_goal)
      else $error("write did not last its tick count");

   c_write: cover property (start ##[1:8] busy);
   c_read: cover property (rd_go ##1 cpu_stall);
   c_expire: cover property ($rose(arm_live) ##5 !arm_live);
   c_irq: cover property (timer_done ##[1:4] ready_irq);
   c_refused: cover property (strobe_wr && !arm_live && !busy);
endmodule
`default_nettype wire

// >>> eac_top_tb_top.sv
// self-checking bench of eac_top: write, read and refused sequences on the i/o port
// assumes eac_core_model supplies the oscillator tick and the flash status
`timescale 1ns/1ns
`default_nettype none
module eac_top_tb_top;
   logic                 clk;
   logic                 rst_n;
   eac_pkg::eac_io_req_t io_req;
   logic [7:0]           io_rdata;
   logic                 cpu_stall;
   logic                 global_irq_en;
   logic                 selfprog_busy;
   logic                 flash_req;
   logic                 rc_tick;
   logic                 ready_irq;
   logic [7:0]           rd_val;
   logic [7:0]           stalls;
   int                   mismatches;
   int                   checks;

   eac_top #(.WRITE_RC_CYCLES(8)) uut (
      .clk(clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
      .cpu_stall(cpu_stall), .global_irq_en(global_irq_en),
      .selfprog_busy(selfprog_busy), .rc_tick(rc_tick), .ready_irq(ready_irq)
   );
   eac_core_model core (
      .clk(clk), .flash_req(flash_req), .rc_tick(rc_tick), .selfprog_busy(selfprog_busy)
   );

   always #4 clk = ~clk;

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // n sets how many cycles after the taking edge cpu_stall is counted
   task automatic io_wr(input logic [5:0] a, input logic [7:0] d, input int n);
      while (cpu_stall !== 1'h0) @(negedge clk);
      io_req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(negedge clk);
      io_req.wr = 1'h0;
      repeat (n) begin
         if (cpu_stall === 1'h1) stalls = stalls + 8'h01;
         @(negedge clk);
      end
   endtask

   task automatic io_rd(input logic [5:0] a);
      while (cpu_stall !== 1'h0) @(negedge clk);
      io_req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
      @(negedge clk);
      io_req.rd = 1'h0;
      @(negedge clk);
      rd_val = io_rdata;
   endtask

   // gap adds idle cycles between arming and strobing; 2 hits the last open cycle
   task automatic do_write(input logic [1:0] m, input logic [7:0] d, input int gap);
      global_irq_en = 1'h0;
      io_wr(eac_pkg::ADDR_DATA, d, 1);
      io_wr(eac_pkg::ADDR_CTRL, {2'h0, m, 4'hC}, 1);
      repeat (gap) @(negedge clk);
      stalls = 8'h00;
      io_wr(eac_pkg::ADDR_CTRL, {2'h0, m, 4'hA}, 8);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         io_rd(eac_pkg::ADDR_CTRL);
         n++;
      end while (rd_val[1] !== 1'h0 && n < 200);
      chk("write done", 8'h00, {7'h00, rd_val[1]});
   endtask

   task automatic rd_byte(input logic [7:0] exp);
      stalls = 8'h00;
      io_wr(eac_pkg::ADDR_CTRL, 8'h09, 8);
      chk("read stall", 8'h04, stalls);
      io_rd(eac_pkg::ADDR_DATA);
      chk("byte", exp, rd_val);
   endtask

   task automatic end_sim();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // the sequence needs a few thousand cycles at most
   initial begin
      #(8 * 20000);
      mismatches++;
      end_sim();
   end

   initial begin
      logic [1:0] md [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      logic [7:0] dt [4] = '{8'h00, 8'h3C, 8'h00, 8'h81};
      logic [7:0] ex [4] = '{8'hFF, 8'h3C, 8'h3C, 8'h81};
      clk = 1'h0;
      rst_n = 1'h0;
      io_req = '0;
      global_irq_en = 1'h0;
      flash_req = 1'h0;
      stalls = 8'h00;
      mismatches = 0;
      checks = 0;
      repeat (6) @(negedge clk);
      rst_n = 1'h1;
      io_rd(eac_pkg::ADDR_CTRL);
      chk("ctrl reset", 8'h00, rd_val);
      io_rd(6'h23);
      chk("unmapped", 8'h00, rd_val);
      io_wr(eac_pkg::ADDR_AHI, 8'hFF, 1);
      io_wr(eac_pkg::ADDR_ALO, 8'h55, 1);
      io_rd(eac_pkg::ADDR_AHI);
      chk("addr high", 8'h03, rd_val);
      io_wr(eac_pkg::ADDR_CTRL, 8'h08, 1);
      global_irq_en = 1'h1;
      @(negedge clk);
      @(negedge clk);
      chk("irq idle", 8'h01, {7'h00, ready_irq});
      global_irq_en = 1'h0;
      @(negedge clk);
      @(negedge clk);
      chk("irq masked", 8'h00, {7'h00, ready_irq});
      do_write(2'h0, 8'hA5, 2);
      chk("write stall", 8'h02, stalls);
      global_irq_en = 1'h1;
      io_rd(eac_pkg::ADDR_CTRL);
      chk("busy bit", 8'h02, rd_val & 8'h02);
      chk("irq busy", 8'h00, {7'h00, ready_irq});
      io_wr(eac_pkg::ADDR_ALO, 8'h00, 1);
      stalls = 8'h00;
      io_wr(eac_pkg::ADDR_CTRL, 8'h09, 8);
      chk("read while busy", 8'h00, stalls);
      io_wr(eac_pkg::ADDR_CTRL, 8'h38, 1);
      wait_idle();
      chk("irq ready", 8'h01, {7'h00, ready_irq});
      chk("ctrl after", 8'h08, rd_val);
      io_rd(eac_pkg::ADDR_ALO);
      chk("addr kept", 8'h55, rd_val);
      rd_byte(8'hA5);
      do_write(2'h0, 8'h11, 3);
      chk("late strobe", 8'h00, stalls);
      stalls = 8'h00;
      io_wr(eac_pkg::ADDR_CTRL, 8'h0A, 8);
      chk("unarmed strobe", 8'h00, stalls);
      flash_req = 1'h1;
      do_write(2'h0, 8'h22, 2);
      chk("flash busy", 8'h00, stalls);
      flash_req = 1'h0;
      rd_byte(8'hA5);
      for (int i = 0; i < 4; i++) begin
         do_write(md[i], dt[i], 0);
         wait_idle();
         rd_byte(ex[i]);
      end
      end_sim();
   end
endmodule
`default_nettype wire
